//--- rtl/jtp_tap_port.sv
// Test access and emulation port, sampled entirely by the system clock.
`timescale 1ns/1ps

module jtp_tap_port
  import jtp_pkg::*;
#(
  // Arbitrary identification value, not tied to any real part.
  parameter logic [DRW-1:0] IDCODE_VALUE = 32'h1234_5001
) (
  // Clock, reset and enable
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic          ce,
  // Test pins from the outside controller
  input  wire jtp_tap_pins_t tapPins,
  output logic               tdo,
  output logic               tdoOe,
  // Emulation lines, split into input, output and enable
  input  wire logic          emuAIn,
  output logic               emuAOut,
  output logic               emuAOe,
  input  wire logic          emuBIn,
  output logic               emuBOut,
  output logic               emuBOe,
  // Core side
  input  wire logic [1:0]    coreEmuReq,
  output logic [1:0]         emuEvent,
  output logic               outputsOff,
  output logic               scanControl
);

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  jtp_state_t s_q;
  jtp_state_t s_d;

  logic tckRise;
  logic tckFall;
  logic tmsNow;
  logic tdiNow;
  logic trstOn;
  logic offNow;
  logic shifting;

  // Edge detection looks only at the second and third sampling stages.
  assign tckRise  = s_q.tckS[1] & ~s_q.tckS[2];
  assign tckFall  = ~s_q.tckS[1] & s_q.tckS[2];
  assign tmsNow   = s_q.tmsS[1];
  assign tdiNow   = s_q.tdiS[1];
  assign trstOn   = s_q.trstS[1];
  assign offNow   = ~trstOn & s_q.emuAS[1] & ~s_q.emuBS[1];
  assign shifting = (s_q.state == ST_SH_DR) | (s_q.state == ST_SH_IR);

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (ce) begin
      s_d.tckS  = {s_q.tckS[1:0], tapPins.tck};
      s_d.tmsS  = {s_q.tmsS[0], tapPins.tms};
      s_d.tdiS  = {s_q.tdiS[0], tapPins.tdi};
      s_d.trstS = {s_q.trstS[0], tapPins.trst};
      s_d.emuAS = {s_q.emuAS[0], emuAIn};
      s_d.emuBS = {s_q.emuBS[0], emuBIn};

      if (!trstOn) begin
        // Functional mode: test clock edges are not even looked at.
        s_d.state  = ST_TLR;
        s_d.ir     = RST_IR;
        s_d.emuCtl = RST_EMU_CTL;
        s_d.tdoOe  = 1'b0;
      end else if (tckRise) begin
        if (s_q.state == ST_CAP_DR) begin
          if (s_q.ir == INS_IDCODE) begin
            s_d.dr = IDCODE_VALUE;
          end else if (s_q.ir == INS_EMUCTL) begin
            s_d.dr = {{(DRW-EMUW){1'b0}}, s_q.emuCtl};
          end else begin
            s_d.dr = '0;
          end
        end
        if (s_q.state == ST_SH_DR) begin
          s_d.dr = drShift(s_q.ir, s_q.dr, tdiNow);
        end
        if (s_q.state == ST_CAP_IR) begin
          s_d.irSh = IR_CAPTURE;
        end
        if (s_q.state == ST_SH_IR) begin
          s_d.irSh = {tdiNow, s_q.irSh[IRW-1:1]};
        end
        s_d.state = tapNext(s_q.state, tmsNow);
      end else if (tckFall) begin
        if (s_q.state == ST_UPD_IR) begin
          s_d.ir = s_q.irSh;
        end
        if (s_q.state == ST_UPD_DR && s_q.ir == INS_EMUCTL) begin
          s_d.emuCtl = s_q.dr[EMUW-1:0];
        end
        if (shifting) begin
          s_d.tdo = (s_q.state == ST_SH_IR) ? s_q.irSh[0] : s_q.dr[0];
        end
        s_d.tdoOe = shifting;
      end

      if (trstOn && s_q.state == ST_TLR) begin
        s_d.ir     = RST_IR;
        s_d.emuCtl = RST_EMU_CTL;
      end

      if (offNow) begin
        s_d.tdoOe = 1'b0;
      end

      // Emulation lines only drive while the scan logic owns the device.
      s_d.emuAOe  = trstOn & s_q.emuCtl[EMU_A_DIR_BIT];
      s_d.emuAOut = coreEmuReq[0];
      s_d.emuBOe  = trstOn & s_q.emuCtl[EMU_B_DIR_BIT];
      s_d.emuBOut = coreEmuReq[1];
      s_d.emuEvent[0] = trstOn & ~s_q.emuCtl[EMU_A_DIR_BIT] & s_q.emuAS[1];
      s_d.emuEvent[1] = trstOn & ~s_q.emuCtl[EMU_B_DIR_BIT] & s_q.emuBS[1];
      s_d.outputsOff  = offNow;
      s_d.scanControl = trstOn;
    end
  end

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.tckS   <= RST_TCK_SYNC;
      s_q.tmsS   <= RST_HIGH_SYNC;
      s_q.tdiS   <= RST_HIGH_SYNC;
      s_q.trstS  <= RST_LOW_SYNC;
      s_q.emuAS  <= RST_HIGH_SYNC;
      s_q.emuBS  <= RST_HIGH_SYNC;
      s_q.state  <= ST_TLR;
      s_q.ir     <= RST_IR;
      s_q.emuCtl <= RST_EMU_CTL;
    end else begin
      s_q <= s_d;
    end
  end

  assign tdo         = s_q.tdo;
  assign tdoOe       = s_q.tdoOe;
  assign emuAOut     = s_q.emuAOut;
  assign emuAOe      = s_q.emuAOe;
  assign emuBOut     = s_q.emuBOut;
  assign emuBOe      = s_q.emuBOe;
  assign emuEvent    = s_q.emuEvent;
  assign outputsOff  = s_q.outputsOff;
  assign scanControl = s_q.scanControl;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_tdo_on_fall;
    $changed(s_q.tdo) |-> $past(ce && tckFall && shifting && trstOn);
  endproperty
  a_tdo_on_fall: assert property (p_tdo_on_fall)
    else $error("TDO changed away from a falling test clock edge");

  property p_tdo_dr_bit;
    ce && trstOn && tckFall && s_q.state == ST_SH_DR
      |=> s_q.tdo == $past(s_q.dr[0]);
  endproperty
  a_tdo_dr_bit: assert property (p_tdo_dr_bit)
    else $error("TDO did not show the data register low bit");

  property p_tdo_float_idle;
    ce && trstOn && tckFall && !shifting |=> !s_q.tdoOe;
  endproperty
  a_tdo_float_idle: assert property (p_tdo_float_idle)
    else $error("TDO driven outside a shift state");

  property p_tdo_float_off;
    ce && offNow |=> !s_q.tdoOe && s_q.outputsOff;
  endproperty
  a_tdo_float_off: assert property (p_tdo_float_off)
    else $error("TDO driven while outputs are disabled");

  property p_func_mode;
    ce && !trstOn |=> s_q.state == ST_TLR && !s_q.emuAOe && !s_q.emuBOe;
  endproperty
  a_func_mode: assert property (p_func_mode)
    else $error("Scan logic active with test reset low");

  property p_tlr_to_rti;
    ce && trstOn && tckRise && s_q.state == ST_TLR && !tmsNow
      |=> s_q.state == ST_RTI;
  endproperty
  a_tlr_to_rti: assert property (p_tlr_to_rti)
    else $error("Controller did not leave reset state on TMS low");

  property p_hold_between_edges;
    ce && !tckRise |=> s_q.state == $past(s_q.state) || !$past(trstOn);
  endproperty
  a_hold_between_edges: assert property (p_hold_between_edges)
    else $error("Controller moved without a rising test clock edge");

  property p_emu_a_out;
    ce && trstOn && s_q.emuCtl[EMU_A_DIR_BIT]
      |=> s_q.emuAOe && s_q.emuAOut == $past(coreEmuReq[0]);
  endproperty
  a_emu_a_out: assert property (p_emu_a_out)
    else $error("Emulation line A not driven as configured");

  property p_emu_b_in;
    ce && trstOn && !s_q.emuCtl[EMU_B_DIR_BIT]
      |=> !s_q.emuBOe && s_q.emuEvent[1] == $past(s_q.emuBS[1]);
  endproperty
  a_emu_b_in: assert property (p_emu_b_in)
    else $error("Emulation line B input not passed to the core");

  property p_off_cond;
    ce && !trstOn && s_q.emuAS[1] && !s_q.emuBS[1]
      |=> s_q.outputsOff && !s_q.tdoOe && !s_q.emuBOe;
  endproperty
  a_off_cond: assert property (p_off_cond)
    else $error("Outputs disable condition not honoured");

  c_shift_dr: cover property (ce && tckRise && s_q.state == ST_SH_DR);
  c_upd_ir: cover property (ce && tckFall && s_q.state == ST_UPD_IR);
  c_off: cover property (s_q.outputsOff);
  c_emu_out: cover property (s_q.emuAOe && s_q.emuBOe);

endmodule : jtp_tap_port

//--- rtl/jtp_pkg.sv
// Package of constants, types and helpers for the test and emulation port.
package jtp_pkg;

  // ---------------------------------------------------------------------
  // Widths, instruction codes and reset values
  // ---------------------------------------------------------------------
  localparam int unsigned IRW = 4;
  localparam int unsigned DRW = 32;
  localparam int unsigned EMUW = 4;

  localparam logic [IRW-1:0] INS_EMUCTL = 4'h8;
  localparam logic [IRW-1:0] INS_IDCODE = 4'hE;
  localparam logic [IRW-1:0] INS_BYPASS = 4'hF;
  localparam logic [IRW-1:0] IR_CAPTURE = 4'h1;

  // Emulation control field: bit 0/1 make line A/B an output.
  localparam int unsigned EMU_A_DIR_BIT = 0;
  localparam int unsigned EMU_B_DIR_BIT = 1;

  localparam logic [2:0] RST_TCK_SYNC = 3'h0;
  localparam logic [1:0] RST_HIGH_SYNC = 2'h3;
  localparam logic [1:0] RST_LOW_SYNC = 2'h0;
  localparam logic [EMUW-1:0] RST_EMU_CTL = 4'h0;
  localparam logic [IRW-1:0] RST_IR = INS_IDCODE;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR,
    ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
    ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } jtp_tap_state_t;

  // Test pins as they arrive from the outside controller.
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst;
  } jtp_tap_pins_t;

  typedef struct packed {
    logic [2:0]      tckS;
    logic [1:0]      tmsS;
    logic [1:0]      tdiS;
    logic [1:0]      trstS;
    logic [1:0]      emuAS;
    logic [1:0]      emuBS;
    jtp_tap_state_t  state;
    logic [IRW-1:0]  ir;
    logic [IRW-1:0]  irSh;
    logic [DRW-1:0]  dr;
    logic [EMUW-1:0] emuCtl;
    logic            tdo;
    logic            tdoOe;
    logic            emuAOut;
    logic            emuAOe;
    logic            emuBOut;
    logic            emuBOe;
    logic            outputsOff;
    logic            scanControl;
    logic [1:0]      emuEvent;
  } jtp_state_t;

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  function automatic jtp_tap_state_t tapNext(jtp_tap_state_t s, logic m);
    jtp_tap_state_t r;
    r = s;
    unique case (s)
      ST_TLR:    r = m ? ST_TLR    : ST_RTI;
      ST_RTI:    r = m ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: r = m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: r = m ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  r = m ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: r = m ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: r = m ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: r = m ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: r = m ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: r = m ? ST_TLR    : ST_CAP_IR;
      ST_CAP_IR: r = m ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  r = m ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: r = m ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: r = m ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: r = m ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: r = m ? ST_SEL_DR : ST_RTI;
    endcase
    return r;
  endfunction : tapNext

  // Data registers shift toward bit 0; the new bit enters at the top end.
  function automatic logic [DRW-1:0] drShift(logic [IRW-1:0] ins,
                                             logic [DRW-1:0] dr,
                                             logic           din);
    logic [DRW-1:0] r;
    r = {{(DRW-1){1'b0}}, din};
    if (ins == INS_IDCODE) begin
      r = {din, dr[DRW-1:1]};
    end else if (ins == INS_EMUCTL) begin
      r = {{(DRW-EMUW){1'b0}}, din, dr[EMUW-1:1]};
    end
    return r;
  endfunction : drShift

endpackage : jtp_pkg

//--- tb/jtp_ctl_model.sv
// Behavioural outside test controller that drives the test link.
`timescale 1ns/1ps
module jtp_ctl_model
  import jtp_pkg::*;
(
  // Clock
  input  wire logic     clk,
  // Test link
  output jtp_tap_pins_t tapPins,
  input  wire logic     tdo,
  input  wire logic     tdoOe,
  // Emulation line drivers
  output logic          emuADrv,
  output logic          emuAEn,
  output logic          emuBDrv,
  output logic          emuBEn
);
  logic tckQ, tmsQ, tdiQ, trstQ, pinsOn;
  int   flipCount;

  // Released pins fall to their pulls, so a loose port stays inactive.
  assign tapPins = {tckQ, pinsOn ? tmsQ : 1'b1, pinsOn ? tdiQ : 1'b1,
                    pinsOn & trstQ};

  initial begin
    {tckQ, tmsQ, tdiQ, trstQ, pinsOn} = 5'h0;
    {emuADrv, emuAEn, emuBDrv, emuBEn} = 4'h0;
    flipCount = 0;
  end

  task automatic setLink(input logic on, input logic trst);
    @(posedge clk);
    pinsOn <= on;
    trstQ  <= trst;
  endtask : setLink

  // Line A is left to its pull-up to ask for outputs disable; this is
  // only ever done for test, never to share a bus.
  task automatic setEmu(input logic aEn, input logic a, input logic bEn,
                        input logic b);
    @(posedge clk);
    {emuAEn, emuADrv, emuBEn, emuBDrv} <= {aEn, a, bEn, b};
  endtask : setEmu

  // One test clock period of eight system clocks; mode and data change on
  // the fall, the output is taken at the rise.
  task automatic step(input logic m, input logic d, output logic o,
                      output logic oe);
    @(posedge clk);
    tckQ <= 1'b0;
    tmsQ <= m;
    tdiQ <= d;
    repeat (4) @(posedge clk);
    tckQ <= 1'b1;
    // A floating output has no pull, so it reads as the inverse here.
    o  = tdoOe ? tdo : ~tdo;
    oe = tdoOe;
    repeat (3) @(posedge clk);
    if (oe && tdo !== o) begin
      flipCount++;
    end
  endtask : step

  // From idle, one instruction or data scan of n bits, back to idle.
  task automatic scan(input logic isIr, input int n, input logic [31:0] din,
                      output logic [31:0] dout, output logic oeAll,
                      output logic oeAfter);
    logic o, oe;
    dout  = 32'h0;
    oeAll = 1'b1;
    step(1'b1, 1'b0, o, oe);
    if (isIr) begin
      step(1'b1, 1'b0, o, oe);
    end
    step(1'b0, 1'b0, o, oe);
    step(1'b0, 1'b0, o, oe);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o, oe);
      dout[i] = o;
      oeAll   = oeAll & oe;
    end
    step(1'b1, 1'b0, o, oeAfter);
    step(1'b0, 1'b0, o, oe);
  endtask : scan
endmodule : jtp_ctl_model

//--- tb/jtp_tap_port_tb_top.sv
// Self-checking bench of the test and emulation port.
`timescale 1ns/1ps
module jtp_tap_port_tb_top
  import jtp_pkg::*;
  ;
  // Arbitrary identification value, not tied to any real part.
  localparam logic [DRW-1:0] ID_VAL = 32'h5A5A_3C01;

  logic          clk, rstn, ce, tdo, tdoOe, outputsOff, scanControl;
  logic          emuAIn, emuAOut, emuAOe, emuBIn, emuBOut, emuBOe;
  logic          emuADrv, emuAEn, emuBDrv, emuBEn;
  logic [1:0]    coreEmuReq, emuEvent;
  jtp_tap_pins_t tapPins;
  int            failures, checkCount;
  logic [31:0]   dout;
  logic          oeAll, oeAfter;

  // Both emulation lines carry pull-ups.
  assign emuAIn = emuAOe ? emuAOut : (emuAEn ? emuADrv : 1'b1);
  assign emuBIn = emuBOe ? emuBOut : (emuBEn ? emuBDrv : 1'b1);

  jtp_tap_port #(.IDCODE_VALUE(ID_VAL)) DUT (
    .clk(clk), .rstn(rstn), .ce(ce), .tapPins(tapPins), .tdo(tdo),
    .tdoOe(tdoOe), .emuAIn(emuAIn), .emuAOut(emuAOut), .emuAOe(emuAOe),
    .emuBIn(emuBIn), .emuBOut(emuBOut), .emuBOe(emuBOe),
    .coreEmuReq(coreEmuReq), .emuEvent(emuEvent), .outputsOff(outputsOff),
    .scanControl(scanControl));

  jtp_ctl_model ctl (
    .clk(clk), .tapPins(tapPins), .tdo(tdo), .tdoOe(tdoOe),
    .emuADrv(emuADrv), .emuAEn(emuAEn), .emuBDrv(emuBDrv), .emuBEn(emuBEn));

  // ---------------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checkCount++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %0h expected %0h", $time, what,
               got, exp);
    end
  endtask : chk

  task automatic endOfTest();
    $display("checks %0d failures %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : endOfTest

  task automatic settle();
    repeat (5) @(posedge clk);
  endtask : settle

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic tReset();
    chk({tdoOe, emuAOe, emuBOe}, 3'h0, "floating after reset");
    chk({outputsOff, scanControl}, 2'h0, "idle after reset");
  endtask : tReset

  // Test reset low: a full scan must leave the port untouched.
  task automatic tIgnored();
    ctl.setLink(1'b1, 1'b0);
    ctl.scan(1'b1, 4, 32'hF, dout, oeAll, oeAfter);
    chk({oeAll, scanControl}, 2'h0, "scan while reset low");
    ctl.setLink(1'b0, 1'b1);
    settle();
    chk(scanControl, 1'b0, "loose reset pin");
  endtask : tIgnored

  task automatic tIrScan();
    logic o, oe;
    ctl.setLink(1'b1, 1'b1);
    settle();
    chk(scanControl, 1'b1, "scan owns device");
    ctl.step(1'b0, 1'b0, o, oe);
    ctl.scan(1'b1, 4, 32'(INS_IDCODE), dout, oeAll, oeAfter);
    chk(dout[3:0], IR_CAPTURE, "instruction capture");
    chk({oeAll, oeAfter}, 2'h2, "drive only while shifting");
    ctl.scan(1'b0, 32, 32'h0, dout, oeAll, oeAfter);
    chk(dout, ID_VAL, "identification");
    chk(ctl.flipCount, 0, "output moved at a rise");
  endtask : tIrScan

  // Bypass returns the sampled data one bit late behind a captured 0.
  task automatic tBypass();
    ctl.scan(1'b1, 4, 32'(INS_BYPASS), dout, oeAll, oeAfter);
    ctl.scan(1'b0, 8, 32'hB4, dout, oeAll, oeAfter);
    chk(dout[7:0], 8'h68, "bypass data");
  endtask : tBypass

  task automatic tEmu();
    coreEmuReq <= 2'h2;
    ctl.scan(1'b1, 4, 32'(INS_EMUCTL), dout, oeAll, oeAfter);
    ctl.scan(1'b0, 4, 32'h3, dout, oeAll, oeAfter);
    chk(dout[3:0], RST_EMU_CTL, "control capture");
    chk({emuAOe, emuAOut}, 2'h2, "line A output");
    chk({emuBOe, emuBOut}, 2'h3, "line B output");
    ctl.scan(1'b0, 4, 32'h1, dout, oeAll, oeAfter);
    chk(dout[3:0], 4'h3, "control read back");
    ctl.setEmu(1'b0, 1'b0, 1'b1, 1'b0);
    settle();
    chk({emuBOe, emuEvent[1]}, 2'h0, "line B input low");
    ctl.setEmu(1'b0, 1'b0, 1'b1, 1'b1);
    settle();
    chk(emuEvent[1], 1'b1, "line B input high");
    ctl.scan(1'b0, 4, 32'h0, dout, oeAll, oeAfter);
    ctl.setEmu(1'b1, 1'b0, 1'b1, 1'b1);
    settle();
    chk({emuAOe, emuEvent}, 3'h2, "line A input low");
    ctl.setLink(1'b1, 1'b0);
    settle();
    chk({emuAOe, emuBOe}, 2'h0, "lines released");
  endtask : tEmu

  task automatic tOff();
    ctl.setEmu(1'b0, 1'b0, 1'b1, 1'b0);
    settle();
    chk({outputsOff, tdoOe}, 2'h2, "outputs disabled");
    ctl.setEmu(1'b0, 1'b0, 1'b1, 1'b1);
    settle();
    chk(outputsOff, 1'b0, "disable released");
    ctl.setEmu(1'b0, 1'b0, 1'b1, 1'b0);
    ctl.setLink(1'b1, 1'b1);
    settle();
    chk(outputsOff, 1'b0, "line B is interrupt");
    chk(emuEvent, 2'h1, "lines read as inputs");
  endtask : tOff

  // Clock enable low freezes every stage, synchronisers included.
  task automatic tFreeze();
    ce <= 1'b0;
    ctl.setEmu(1'b0, 1'b0, 1'b1, 1'b1);
    settle();
    chk(emuEvent, 2'h1, "frozen while disabled");
    ce <= 1'b1;
    settle();
    chk(emuEvent, 2'h3, "resumed after enable");
  endtask : tFreeze

  // ---------------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    coreEmuReq = 2'h0;
    failures = 0;
    checkCount = 0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    settle();
    tReset();
    tIgnored();
    tIrScan();
    tBypass();
    tEmu();
    tOff();
    tFreeze();
    endOfTest();
  end

  // A hang counts as a mismatch and still reaches the verdict.
  initial begin
    repeat (60000) @(posedge clk);
    $display("mismatch at %0t: run timed out", $time);
    failures++;
    endOfTest();
  end
endmodule : jtp_tap_port_tb_top
